// >>> rtl/omd_params.svh
// constants for the optical module management target: bus addresses,
// memory layout, pin reset values and the laser shut-off time.
// assumes a 200 MHz core clock; included by the design files by bare name.
`ifndef OMD_PARAMS_SVH
`define OMD_PARAMS_SVH

`define OMD_ID_DEV_ADDR 7'h50
`define OMD_DIAG_DEV_ADDR 7'h51
`define OMD_ID_TYPE_ADDR 8'h5C
`define OMD_ID_TYPE_VAL 8'h60
`define OMD_THR_LAST 8'h27
`define OMD_RD_FIRST 8'h60
`define OMD_RD_LAST 8'h69
`define OMD_ALARM_ADDR 8'h70
`define OMD_WARN_ADDR 8'h74
`define OMD_BITS_PER_BYTE 4'h8
`define OMD_PIN_RST 6'h07
`define OMD_CLK_PS 5000
`define OMD_TX_OFF_US 10

`endif

// >>> rtl/omd_pkg.sv
// types shared by the optical module management target.
// assumes the constants header is available to the design files.
package omd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WORD = 3'b010,
    ST_WRITE = 3'b011,
    ST_ACK = 3'b100,
    ST_READ = 3'b101,
    ST_RACK = 3'b110
  } omd_state_type;
endpackage : omd_pkg

// >>> rtl/omd_mem_if.sv
// byte port between the serial engine and the management memories.
// assumes one clock domain; read data answers combinationally.
`timescale 1ns/1ps
interface omd_mem_if;
  logic page;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;
  modport engine (output page, output addr, output wdata, output we, input rdata);
  modport store (input page, input addr, input wdata, input we, output rdata);
endinterface : omd_mem_if

// >>> rtl/omd_sync.sv
// two-stage synchroniser for a group of pin inputs.
// assumes the inputs are asynchronous to clock_i; each bit has its own reset level.
`timescale 1ns/1ps
module omd_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule : omd_sync

// >>> rtl/omd_mem.sv
// identification page and diagnostic page behind the serial engine.
// assumes readings arrive calibrated from monitor logic on clock_i.
`timescale 1ns/1ps
`include "omd_params.svh"
module omd_mem #(
  parameter logic [2047:0] ID_CONTENT = {8'h03, 2040'h0},
  parameter logic [319:0] THRESH = {5{16'hF000, 16'h1000, 16'hE000, 16'h2000}}
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  omd_mem_if.store m,
  input wire logic [79:0] readings_i
);
  logic [7:0] user_q [128];
  logic [7:0] user_d [128];
  logic [9:0] alarm_d;
  logic [9:0] alarm_q;
  logic [9:0] warn_d;
  logic [9:0] warn_q;

  // out-of-range compare per monitored quantity, thresholds are fixed at build
  for (genvar g = 0; g < 5; g++) begin : g_mon
    logic [15:0] val;
    assign val = readings_i[79-16*g -: 16];
    assign alarm_d[9-2*g] = val > THRESH[319-64*g -: 16];
    assign alarm_d[8-2*g] = val < THRESH[303-64*g -: 16];
    assign warn_d[9-2*g] = val > THRESH[287-64*g -: 16];
    assign warn_d[8-2*g] = val < THRESH[271-64*g -: 16];
  end

  // only the upper half of the diagnostic page takes writes
  always_comb begin
    user_d = user_q;
    if (m.we && m.page && m.addr[7]) begin
      user_d[m.addr[6:0]] = m.wdata;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 128; i++) begin
        user_q[i] <= 8'h00;
      end
      alarm_q <= 10'h000;
      warn_q <= 10'h000;
    end else if (ce_i) begin
      user_q <= user_d;
      alarm_q <= alarm_d;
      warn_q <= warn_d;
    end
  end

  // read decode; the identification page is read-only content
  always_comb begin
    if (!m.page && m.addr == `OMD_ID_TYPE_ADDR) begin
      m.rdata = `OMD_ID_TYPE_VAL;
    end else if (!m.page) begin
      m.rdata = ID_CONTENT[2047-8*m.addr -: 8];
    end else if (m.addr <= `OMD_THR_LAST) begin
      m.rdata = THRESH[319-8*m.addr -: 8];
    end else if (m.addr >= `OMD_RD_FIRST && m.addr <= `OMD_RD_LAST) begin
      m.rdata = readings_i[79-8*(m.addr-`OMD_RD_FIRST) -: 8];
    end else if (m.addr == `OMD_ALARM_ADDR) begin
      m.rdata = alarm_q[9:2];
    end else if (m.addr == `OMD_ALARM_ADDR + 8'h01) begin
      m.rdata = {alarm_q[1:0], 6'h00};
    end else if (m.addr == `OMD_WARN_ADDR) begin
      m.rdata = warn_q[9:2];
    end else if (m.addr == `OMD_WARN_ADDR + 8'h01) begin
      m.rdata = {warn_q[1:0], 6'h00};
    end else if (m.addr[7]) begin
      m.rdata = user_q[m.addr[6:0]];
    end else begin
      m.rdata = 8'h00;
    end
  end

  chk_alarm_temp_high: assert property (@(posedge clock_i) disable iff (rst_i || !ce_i)
    (readings_i[79:64] > THRESH[319:304]) |=> alarm_q[9])
    else $error("temperature high alarm not raised");
  chk_user_write_lands: assert property (@(posedge clock_i) disable iff (rst_i || !ce_i)
    (m.we && m.page && m.addr[7]) |=> user_q[$past(m.addr[6:0])] == $past(m.wdata))
    else $error("user byte write lost");
  chk_temp_readout: assert property (@(posedge clock_i) disable iff (rst_i)
    (m.page && m.addr == `OMD_RD_FIRST) |-> m.rdata == readings_i[79:72])
    else $error("temperature byte not returned");
endmodule : omd_mem

// >>> rtl/omd_target.sv
// management side of a pluggable optical module: two-wire serial target with
// identification and diagnostic pages, plus laser and signal-loss pins.
// assumes pins are asynchronous to clock_i (200 MHz); the host makes the link clock.
`timescale 1ns/1ps
`include "omd_params.svh"

// Behaviour
// - answer identification page of 256 bytes at bus address 1010000X
// - answer diagnostic page at bus address 1010001X, identification page unchanged
// - sample data on rising clock edge; writes land only in unprotected bytes
// - change driven data only after a falling clock edge
// - 8-bit words, single addressed and sequential accesses
// - identification page holds read-only descriptive content
// - diagnostic page shows live temperature, bias, powers and supply readings
// - alarm and warning flags set when a reading leaves its range
// - readings are reported internally calibrated by default
// - signal-loss output low on normal reception, high without signal
// - receive data valid only while signal-loss is low
// - transmitter off within 10 us of laser-off assertion
// - transmitter off while laser-off high or open, on while low
// - laser-error output high on any laser fault, else low
// - module-present pin held permanently low
module omd_target #(
  parameter logic [2047:0] ID_CONTENT = {8'h03, 2040'h0},
  parameter logic [319:0] THRESH = {5{16'hF000, 16'h1000, 16'hE000, 16'h2000}}
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic id_link_clock_pin_i,
  input wire logic id_link_data_pin_i,
  output logic id_link_data_pin_o,
  output logic id_link_data_pin_oe_o,
  output logic module_present_pin_o,
  input wire logic laser_off_i,
  input wire logic laser_fault_i,
  output logic laser_error_o,
  output logic transmit_enable_o,
  input wire logic no_light_i,
  output logic no_light_flag_o,
  input wire logic rx_data_i,
  output logic rx_data_o,
  input wire logic [15:0] temp_i,
  input wire logic [15:0] supply_i,
  input wire logic [15:0] bias_i,
  input wire logic [15:0] tx_power_i,
  input wire logic [15:0] rx_power_i
);
  localparam int TX_OFF_CYCLES = (`OMD_TX_OFF_US * 1000000) / `OMD_CLK_PS;

  logic [5:0] pin_s;
  logic scl_s;
  logic sda_s;
  logic laser_off_s;
  logic no_light_s;
  logic fault_s;
  logic rx_s;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  omd_pkg::omd_state_type state_d;
  omd_pkg::omd_state_type state_q;
  omd_pkg::omd_state_type nxt_d;
  omd_pkg::omd_state_type nxt_q;
  logic [3:0] cnt_d;
  logic [3:0] cnt_q;
  logic [7:0] shift_d;
  logic [7:0] shift_q;
  logic [7:0] ptr_d;
  logic [7:0] ptr_q;
  logic page_d;
  logic page_q;
  logic ack_d;
  logic ack_q;
  logic oe_d;
  logic oe_q;
  logic wr_now;
  logic tx_en_d;
  logic tx_en_q;
  logic err_q;
  logic los_q;
  logic rx_d;
  logic rx_q;
  logic present_q;
  logic sda_low_q;
  logic [11:0] off_cnt_q;

  omd_mem_if mif ();

  // every pin crosses two flops; laser-off and the bus lines idle high
  omd_sync #(
    .WIDTH(6),
    .RST_VAL(`OMD_PIN_RST)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i({rx_data_i, laser_fault_i, no_light_i, laser_off_i, id_link_data_pin_i,
              id_link_clock_pin_i}),
    .sync_o(pin_s)
  );

  assign scl_s = pin_s[0];
  assign sda_s = pin_s[1];
  assign laser_off_s = pin_s[2];
  assign no_light_s = pin_s[3];
  assign fault_s = pin_s[4];
  assign rx_s = pin_s[5];

  omd_mem #(
    .ID_CONTENT(ID_CONTENT),
    .THRESH(THRESH)
  ) u_mem (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .m(mif.store),
    .readings_i({temp_i, supply_i, bias_i, tx_power_i, rx_power_i})
  );

  // one pointer serves both pages; the page is picked by the bus address
  assign mif.page = page_q;
  assign mif.addr = ptr_q;
  assign mif.wdata = shift_q;
  assign mif.we = wr_now;

  // edge and framing detection on the synchronised bus lines
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (ce_i) begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign start_seen = scl_s && sda_prev_q && !sda_s;
  assign stop_seen = scl_s && !sda_prev_q && sda_s;

  // serial engine; we only move the data line after a falling clock edge,
  // so our own drive can never look like a start or stop to ourselves
  always_comb begin
    state_d = state_q;
    nxt_d = nxt_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    page_d = page_q;
    ack_d = ack_q;
    oe_d = oe_q;
    wr_now = 1'b0;
    if (start_seen) begin
      state_d = omd_pkg::ST_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop_seen) begin
      state_d = omd_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        omd_pkg::ST_ADDR, omd_pkg::ST_WORD, omd_pkg::ST_WRITE: begin
          if (scl_rise && cnt_q != `OMD_BITS_PER_BYTE) begin
            shift_d = {shift_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `OMD_BITS_PER_BYTE) begin
            oe_d = 1'b1;
            state_d = omd_pkg::ST_ACK;
            nxt_d = omd_pkg::ST_WRITE;
            if (state_q == omd_pkg::ST_ADDR) begin
              if (shift_q[7:1] == `OMD_ID_DEV_ADDR || shift_q[7:1] == `OMD_DIAG_DEV_ADDR) begin
                page_d = shift_q[1];
                nxt_d = shift_q[0] ? omd_pkg::ST_READ : omd_pkg::ST_WORD;
              end else begin
                oe_d = 1'b0;
                state_d = omd_pkg::ST_IDLE;
              end
            end else if (state_q == omd_pkg::ST_WORD) begin
              ptr_d = shift_q;
            end else begin
              wr_now = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        omd_pkg::ST_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            cnt_d = 4'h0;
            state_d = nxt_q;
            if (nxt_q == omd_pkg::ST_READ) begin
              shift_d = mif.rdata;
              oe_d = !mif.rdata[7];
              cnt_d = 4'h1;
            end
          end
        end
        omd_pkg::ST_READ: begin
          if (scl_fall && cnt_q == `OMD_BITS_PER_BYTE) begin
            oe_d = 1'b0;
            ptr_d = ptr_q + 8'h01;
            state_d = omd_pkg::ST_RACK;
          end else if (scl_fall) begin
            shift_d = {shift_q[6:0], 1'b0};
            oe_d = !shift_q[6];
            cnt_d = cnt_q + 4'h1;
          end
        end
        omd_pkg::ST_RACK: begin
          if (scl_rise) begin
            ack_d = !sda_s;
          end else if (scl_fall && ack_q) begin
            shift_d = mif.rdata;
            oe_d = !mif.rdata[7];
            cnt_d = 4'h1;
            state_d = omd_pkg::ST_READ;
          end else if (scl_fall) begin
            state_d = omd_pkg::ST_IDLE;
          end
        end
        default: begin
          state_d = omd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= omd_pkg::ST_IDLE;
      nxt_q <= omd_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      page_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      nxt_q <= nxt_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      page_q <= page_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
    end
  end

  // laser and receiver pins; shut-off takes a few cycles, far inside the limit
  always_comb begin
    tx_en_d = !laser_off_s;
    rx_d = rx_s && !no_light_s;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_en_q <= 1'b0;
      err_q <= 1'b0;
      los_q <= 1'b0;
      rx_q <= 1'b0;
      present_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (ce_i) begin
      tx_en_q <= tx_en_d;
      err_q <= fault_s;
      los_q <= no_light_s;
      rx_q <= rx_d;
      present_q <= 1'b0;
      sda_low_q <= 1'b0;
    end
  end

  assign id_link_data_pin_o = sda_low_q;
  assign id_link_data_pin_oe_o = oe_q;
  assign module_present_pin_o = present_q;
  assign laser_error_o = err_q;
  assign transmit_enable_o = tx_en_q;
  assign no_light_flag_o = los_q;
  assign rx_data_o = rx_q;

  // helper: cycles the transmitter stays on after laser-off is seen
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      off_cnt_q <= 12'h000;
    end else if (ce_i) begin
      off_cnt_q <= (laser_off_s && tx_en_q) ? off_cnt_q + 12'h001 : 12'h000;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i || !ce_i);

  chk_addr_match_ack: assert property (
    (state_q == omd_pkg::ST_ADDR && state_d == omd_pkg::ST_ACK)
    |-> (shift_q[7:2] == 6'h28))
    else $error("acknowledged a foreign bus address");
  chk_page_select: assert property (
    (state_q == omd_pkg::ST_ADDR && state_d == omd_pkg::ST_ACK) |=> page_q == $past(shift_q[1]))
    else $error("page not taken from bus address");
  chk_drive_on_fall: assert property (
    $rose(oe_q) |-> $past(scl_fall))
    else $error("data line driven outside a falling edge");
  chk_shift_on_rise: assert property (
    (state_q == omd_pkg::ST_WORD && scl_rise && !start_seen && !stop_seen && cnt_q < 4'h8)
    |=> shift_q == {$past(shift_q[6:0]), $past(sda_s)})
    else $error("bit not shifted on rising edge");
  chk_ptr_advance: assert property (
    (state_q == omd_pkg::ST_READ && scl_fall && cnt_q == 4'h8 && !start_seen && !stop_seen)
    |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance after read byte");
  chk_tx_off_bound: assert property (
    off_cnt_q < TX_OFF_CYCLES)
    else $error("transmitter left on too long");
  chk_tx_follow: assert property (
    laser_off_s |=> !transmit_enable_o ##1 !transmit_enable_o || !$past(laser_off_s))
    else $error("transmitter on while laser-off high");
  chk_los_gate: assert property (
    no_light_s |=> no_light_flag_o && !rx_data_o)
    else $error("signal loss not flagged or data not blanked");
  chk_los_clear: assert property (
    !no_light_s |=> !no_light_flag_o)
    else $error("signal loss flag high without cause");
  chk_fault_out: assert property (
    fault_s |=> laser_error_o)
    else $error("laser fault not reported");
  chk_present_low: assert property (
    !module_present_pin_o)
    else $error("module present pin not low");

  cov_addr_ack: cover property (state_q == omd_pkg::ST_ADDR ##1 state_q == omd_pkg::ST_ACK);
  cov_byte_write: cover property (wr_now && page_q && ptr_q[7]);
  cov_seq_read: cover property (state_q == omd_pkg::ST_RACK && ack_q && scl_fall);
endmodule : omd_target

// >>> tb/omd_host_model.sv
// host side of the two-wire management link: bus master with frame and byte tasks.
// assumes the bench resolves the open-drain data wire and feeds the level back on sda_i.
`timescale 1ns/1ps
module omd_host_model (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  // link clock rests high between frames; nothing but this model ever drives it
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // opening or repeated start: data falls while the clock is high
  task automatic start;
    #10 sda_low_o = 1'b0;
    #30 scl_o = 1'b1;
    #20 sda_low_o = 1'b1;
    #20 scl_o = 1'b0;
  endtask : start

  // closing: data rises while the clock is high, then the clock stands still
  task automatic stop;
    #10 sda_low_o = 1'b1;
    #30 scl_o = 1'b1;
    #20 sda_low_o = 1'b0;
    #20;
  endtask : stop

  // data set a quarter into the low phase, sampled mid high phase, so no edge races the target
  task automatic clock_bit(input logic low, output logic seen);
    #10 sda_low_o = low;
    #30 scl_o = 1'b1;
    #20 seen = sda_i;
    #20 scl_o = 1'b0;
  endtask : clock_bit

  // one byte out, msb first, then the acknowledge slot with the line released
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(!b[i], s);
    clock_bit(1'b0, ack);
  endtask : put_byte

  // one byte in; the last byte of a read is refused so the target lets go
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b0, b[i]);
    clock_bit(!last, s);
  endtask : get_byte
endmodule : omd_host_model

// >>> tb/omd_target_bench.sv
// self-checking bench for the optical module management target.
// assumes default page contents and thresholds; the host model drives the link.
`timescale 1ns/1ps
`include "omd_params.svh"
module omd_target_bench;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl, host_low, dut_oe, dut_do, present, l_off, l_flt, l_err, tx_en;
  logic nol, nol_flag, rxd, rxd_o, ack_seen;
  logic ce = 1'b1;
  logic [7:0] b_seen;
  // shut-off limit in core clocks, worked out from the header's time and period
  localparam int TX_OFF_LIMIT = (`OMD_TX_OFF_US * 1000000) / `OMD_CLK_PS;
  logic [15:0] temp, supply, bias, txp, rxp;
  int err_count = 0;
  int tests_run = 0;
  // open-drain wire: pulled up unless either party pulls it low
  wire sda = (dut_oe ? dut_do : 1'b1) & !host_low;

  // 200 MHz core clock
  always #2.5 clock_i = ~clock_i;

  omd_host_model host_u (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda));

  omd_target dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
    .id_link_clock_pin_i(scl), .id_link_data_pin_i(sda),
    .id_link_data_pin_o(dut_do), .id_link_data_pin_oe_o(dut_oe),
    .module_present_pin_o(present), .laser_off_i(l_off), .laser_fault_i(l_flt),
    .laser_error_o(l_err), .transmit_enable_o(tx_en), .no_light_i(nol),
    .no_light_flag_o(nol_flag), .rx_data_i(rxd), .rx_data_o(rxd_o),
    .temp_i(temp), .supply_i(supply), .bias_i(bias), .tx_power_i(txp),
    .rx_power_i(rxp)
  );

  task automatic final_report;
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // the target may only start pulling the data line while the link clock is low
  // and, being open drain, it may only ever pull towards low
  always @(posedge dut_oe) begin
    check({7'h00, scl}, 8'h00);
    check({7'h00, dut_do}, 8'h00);
  end

  // set pointer, repeated start, read n bytes and compare each, host nack on the last
  task automatic read_chk(input logic [6:0] dev, input logic [7:0] ptr, input int n,
                          input logic [79:0] exp);
    logic a;
    logic [7:0] b;
    host_u.start();
    host_u.put_byte({dev, 1'b0}, a);
    check({7'h00, a}, 8'h00);
    host_u.put_byte(ptr, a);
    check({7'h00, a}, 8'h00);
    host_u.start();
    host_u.put_byte({dev, 1'b1}, a);
    check({7'h00, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      host_u.get_byte(i == n - 1, b);
      check(b, exp[8 * (n - 1 - i) +: 8]);
    end
    host_u.stop();
  endtask : read_chk

  // sequential write of n bytes; every byte is acknowledged, protected or not
  task automatic write_chk(input logic [6:0] dev, input logic [7:0] ptr, input int n,
                           input logic [79:0] data);
    logic a;
    host_u.start();
    host_u.put_byte({dev, 1'b0}, a);
    check({7'h00, a}, 8'h00);
    host_u.put_byte(ptr, a);
    check({7'h00, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      host_u.put_byte(data[8 * (n - 1 - i) +: 8], a);
      check({7'h00, a}, 8'h00);
    end
    host_u.stop();
  endtask : write_chk

  // bounded wait for the transmitter state; gives up at twice the shut-off limit
  task automatic wait_tx(input logic v);
    int n;
    n = 0;
    while (tx_en !== v && n < 2 * TX_OFF_LIMIT) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    check({7'h00, n <= TX_OFF_LIMIT}, 8'h01);
    if (n >= 2 * TX_OFF_LIMIT) final_report();
  endtask : wait_tx

  // main sequence: pins first, then the two pages over the link
  initial begin
    l_off = 1'b1;
    l_flt = 1'b0;
    nol = 1'b0;
    rxd = 1'b0;
    temp = 16'hF100;
    supply = 16'h0800;
    bias = 16'h8000;
    txp = 16'h8000;
    rxp = 16'h1800;
    repeat (16) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    check({7'h00, present}, 8'h00);
    check({7'h00, tx_en}, 8'h00);
    l_off = 1'b0;
    wait_tx(1'b1);
    l_off = 1'b1;
    wait_tx(1'b0);
    // clock enable low freezes every flop, so a laser-off change must not reach the pin
    ce = 1'b0;
    l_off = 1'b0;
    repeat (8) @(posedge clock_i);
    #1;
    check({7'h00, tx_en}, 8'h00);
    ce = 1'b1;
    wait_tx(1'b1);
    l_off = 1'b1;
    wait_tx(1'b0);
    // every mix of laser fault and signal loss, with live receive data
    for (int v = 0; v < 4; v++) begin
      @(posedge clock_i);
      #1;
      nol = v[0];
      l_flt = v[1];
      rxd = 1'b1;
      repeat (6) @(posedge clock_i);
      #1;
      check({7'h00, l_err}, {7'h00, v[1]});
      check({7'h00, nol_flag}, {7'h00, v[0]});
      check({7'h00, rxd_o}, {7'h00, !v[0]});
    end
    read_chk(`OMD_ID_DEV_ADDR, 8'h00, 2, 80'h0300);
    read_chk(`OMD_ID_DEV_ADDR, `OMD_ID_TYPE_ADDR, 1, 80'h60);
    write_chk(`OMD_ID_DEV_ADDR, `OMD_ID_TYPE_ADDR, 1, 80'hAA);
    read_chk(`OMD_ID_DEV_ADDR, `OMD_ID_TYPE_ADDR, 1, 80'h60);
    write_chk(`OMD_DIAG_DEV_ADDR, 8'h80, 3, 80'hAA55C3);
    read_chk(`OMD_DIAG_DEV_ADDR, 8'h80, 3, 80'hAA55C3);
    // current-address read: no pointer byte, the target goes on from where it stood
    read_chk(`OMD_DIAG_DEV_ADDR, 8'h81, 1, 80'h55);
    host_u.start();
    host_u.put_byte({`OMD_DIAG_DEV_ADDR, 1'b1}, ack_seen);
    check({7'h00, ack_seen}, 8'h00);
    host_u.get_byte(1'b1, b_seen);
    check(b_seen, 8'hC3);
    host_u.stop();
    read_chk(`OMD_ID_DEV_ADDR, 8'h80, 1, 80'h00);
    write_chk(`OMD_DIAG_DEV_ADDR, 8'h00, 1, 80'h55);
    read_chk(`OMD_DIAG_DEV_ADDR, 8'h00, 2, 80'hF000);
    read_chk(`OMD_DIAG_DEV_ADDR, 8'h60, 10, {temp, supply, bias, txp, rxp});
    read_chk(`OMD_DIAG_DEV_ADDR, 8'h70, 6, 80'h900000009040);
    // a foreign device byte must go unanswered
    host_u.start();
    host_u.put_byte({7'h52, 1'b0}, ack_seen);
    check({7'h00, ack_seen}, 8'h01);
    host_u.stop();
    // readings back inside every range clear the flags
    @(posedge clock_i);
    #1;
    temp = 16'h8000;
    supply = 16'h8000;
    rxp = 16'h8000;
    read_chk(`OMD_DIAG_DEV_ADDR, 8'h70, 6, 80'h0);
    final_report();
  end
endmodule : omd_target_bench
